// ---- abort_fault_recorder_tb.sv ----
// Self-checking bench for the abort fault recorder.
`timescale 1ns/1ps
module abort_fault_recorder_tb;
  import afr_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  afr_abort_t abort_in = '0;
  logic [3:0] s_awaddr = '0, s_wstrb = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, abort_virtual_address;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  afr_cause_t abort_cause_status;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #5 clk = ~clk;
  afr_recorder dut_u (.clk, .rst_n, .abort_in, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bvalid, .s_bresp, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rvalid, .s_rdata,
    .s_rresp, .s_rready, .abort_cause_status, .abort_virtual_address);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Address and data may be taken on different edges, so each is released on its own.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw |= s_awready;
      w |= s_wready;
      if (aw) s_awvalid <= 1'h0;
      if (w) s_wvalid <= 1'h0;
    end
    do @(posedge clk); while (s_bvalid !== 1'h1);
    s_bready <= 1'h0;
    chk(32'(s_bresp), 32'(r));
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(posedge clk); while (s_rvalid !== 1'h1);
    s_arvalid <= 1'h0;
    s_rready <= 1'h0;
    chk(s_rdata, e);
    chk(32'(s_rresp), 32'(r));
    @(posedge clk);
  endtask
  task automatic ab(input afr_kind_t k, input logic [9:0] c, input logic [31:0] v);
    abort_in <= {1'h1, k, c, v};
    @(posedge clk);
  endtask
  task automatic settle(input logic [9:0] ec, input logic [31:0] ea);
    abort_in <= '0;
    @(posedge clk);
    chk(32'(abort_cause_status), 32'(ec));
    chk(abort_virtual_address, ea);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(4'h0, 32'h0, 2'h0);
    rd(4'h4, 32'h0, 2'h0);
    rd(4'hC, 32'h0, 2'h2);
    ab(AFR_DATA, 10'h2A5, 32'h1234_5678);
    settle(10'h2A5, 32'h1234_5678);
    rd(4'h0, 32'h0000_04A5, 2'h0);
    rd(4'h8, 32'h1, 2'h0);
    ab(AFR_PREFETCH, 10'h232, 32'hFFFF_0000);
    settle(10'h202, 32'h1234_5678);
    rd(4'h0, 32'h0000_0402, 2'h0);
    rd(4'h8, 32'h0, 2'h0);
    ab(AFR_DATA, 10'h111, 32'h0000_0010);
    ab(AFR_DATA, 10'h3F4, 32'hCAFE_0000);
    settle(10'h104, 32'hCAFE_0000);
    rd(4'h0, 32'h0000_0204, 2'h0);
    wr(4'h0, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(4'h0, 32'h0000_06FF, 2'h0);
    wr(4'h0, 32'h0, 4'h1, 2'h0);
    rd(4'h0, 32'h0000_0600, 2'h0);
    wr(4'h4, 32'hDEAD_BEEF, 4'hF, 2'h0);
    rd(4'h4, 32'hDEAD_BEEF, 2'h0);
    wr(4'h8, 32'h0, 4'hF, 2'h0);
    rd(4'h8, 32'h1, 2'h0);
    wr(4'hC, 32'h1, 4'hF, 2'h2);
    ab(AFR_DATA, 10'h0A7, 32'h0BAD_F00D);
    settle(10'h0A7, 32'h0BAD_F00D);
    give_verdict;
  end
endmodule

// ---- afr_defines.svh ----
// Constants for the abort fault recorder: offsets, field positions and reset values.
// How it works
// - A separate kind register at offset 8 records which abort was taken, prefetch or data, not the cause status register's fields.
// - Bit 10 is the extension bit that widens the status code for both abort kinds.
// - Bit 9 is set when the abort came from a debug event, whose exact cause sits in the debug unit.
// - With the debug flag set, the domain field and extension bit have no defined value.
// - Every abort entry loads the cause status register with the source of that abort.
// - No software clear is needed; each new abort simply overwrites the fields.
// - Bits 31 to 11 are reserved and read zero here, bit 8 always reads zero, writes to them are dropped.
// - Bits 7 to 4 hold the domain, one of sixteen, accessed when a data abort occurred.
// - Bits 3 to 0 hold the status code for the type of access being attempted.
// - The 32-bit address register holds the remapped virtual address of the faulting data access.
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH
`define AFR_OFS_CAUSE 4'h0
`define AFR_OFS_ADDR 4'h4
`define AFR_OFS_KIND 4'h8
`define AFR_BIT_EXT 10
`define AFR_BIT_DBG 9
`define AFR_DOM_HI 7
`define AFR_DOM_LO 4
`define AFR_STS_HI 3
`define AFR_STS_LO 0
`define AFR_RST_CAUSE 11'h000
`define AFR_RST_ADDR 32'h0000_0000
`define AFR_RESP_OKAY 2'b00
`define AFR_RESP_SLVERR 2'b10
`endif

// ---- afr_monitor.sv ----
// Port checker for the abort fault recorder.
`timescale 1ns/1ps
module afr_monitor
  import afr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire afr_abort_t abort_in,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_bvalid,
  input wire afr_cause_t abort_cause_status,
  input wire logic [31:0] abort_virtual_address
);
  afr_cause_t cs;
  afr_cause_t ci;
  assign cs = abort_cause_status;
  assign ci = abort_in.cause;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hit; abort_in.valid; endsequence
  sequence s_dat; abort_in.valid && abort_in.kind == AFR_DATA; endsequence
  a_status_load: assert property (s_hit |=> cs.status == $past(ci.status))
    else $error("status not captured");
  a_debug_flag: assert property (s_hit |=> cs.dbg == $past(ci.dbg))
    else $error("debug flag not captured");
  a_ext_bit: assert property (s_hit ##0 !ci.dbg |=> cs.ext == $past(ci.ext))
    else $error("extension bit not captured");
  a_data_domain: assert property (s_dat ##0 !ci.dbg |=> cs.domain == $past(ci.domain))
    else $error("domain not captured");
  a_data_address: assert property (s_dat |=> abort_virtual_address == $past(abort_in.vaddr))
    else $error("address not captured with status");
  // A cause may only move on an abort or on a completed write.
  a_hold_cause: assert property (!$past(abort_in.valid) && !$rose(s_bvalid) |-> $stable(cs))
    else $error("cause changed without cause");
  a_hold_address: assert property (!$past(abort_in.valid) && !$rose(s_bvalid) |-> $stable(abort_virtual_address))
    else $error("address changed without cause");
  a_read_answer: assert property (s_arvalid && !s_arready && !s_rvalid |=> s_arready && s_rvalid)
    else $error("read not answered");
endmodule
bind afr_recorder afr_monitor mon_u (.clk, .rst_n, .abort_in, .s_arvalid, .s_arready, .s_rvalid, .s_bvalid,
  .abort_cause_status, .abort_virtual_address);

// ---- afr_pkg.sv ----
// Types for the abort fault recorder.
package afr_pkg;
  typedef enum logic {AFR_PREFETCH, AFR_DATA} afr_kind_t;
  typedef struct packed {
    logic ext;
    logic dbg;
    logic [3:0] domain;
    logic [3:0] status;
  } afr_cause_t;
  typedef struct packed {
    logic valid;
    afr_kind_t kind;
    afr_cause_t cause;
    logic [31:0] vaddr;
  } afr_abort_t;
  typedef struct packed {
    afr_cause_t cause_r;
    afr_kind_t kind_r;
    logic [31:0] addr_r;
    logic [3:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
  } afr_state_t;
endpackage

// ---- afr_recorder.sv ----
// Abort fault recorder with AXI4-Lite register access.
`timescale 1ns/1ps
`include "afr_defines.svh"
module afr_recorder
  import afr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire afr_abort_t abort_in,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic s_bvalid,
  output logic [1:0] s_bresp,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic s_rvalid,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  input wire logic s_rready,
  output afr_cause_t abort_cause_status,
  output logic [31:0] abort_virtual_address
);
  afr_state_t st_r;
  afr_state_t st_nxt;
  logic do_write;
  logic [31:0] cause_word;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cause_word = {21'h000000, st_r.cause_r.ext, st_r.cause_r.dbg, 1'b0,
                  st_r.cause_r.domain, st_r.cause_r.status};
    if (s_awvalid && !st_r.aw_held_r) begin
      st_nxt.aw_held_r = 1'b1;
      st_nxt.awaddr_r = s_awaddr;
    end
    if (s_wvalid && !st_r.w_held_r) begin
      st_nxt.w_held_r = 1'b1;
      st_nxt.wdata_r = s_wdata;
      st_nxt.wstrb_r = s_wstrb;
    end
    do_write = st_r.aw_held_r && st_r.w_held_r && !st_r.bvalid_r;
    if (do_write) begin
      st_nxt.aw_held_r = 1'b0;
      st_nxt.w_held_r = 1'b0;
      st_nxt.bvalid_r = 1'b1;
      st_nxt.bresp_r = `AFR_RESP_OKAY;
      unique case (st_r.awaddr_r)
        `AFR_OFS_CAUSE: begin
          // Reserved bits and bit 8 are dropped, only the live fields take the write.
          if (st_r.wstrb_r[0]) begin
            st_nxt.cause_r.domain = st_r.wdata_r[`AFR_DOM_HI:`AFR_DOM_LO];
            st_nxt.cause_r.status = st_r.wdata_r[`AFR_STS_HI:`AFR_STS_LO];
          end
          if (st_r.wstrb_r[1]) begin
            st_nxt.cause_r.ext = st_r.wdata_r[`AFR_BIT_EXT];
            st_nxt.cause_r.dbg = st_r.wdata_r[`AFR_BIT_DBG];
          end
        end
        `AFR_OFS_ADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (st_r.wstrb_r[b]) begin
              st_nxt.addr_r[b*8 +: 8] = st_r.wdata_r[b*8 +: 8];
            end
          end
        end
        `AFR_OFS_KIND: st_nxt.bresp_r = `AFR_RESP_OKAY;
        default: st_nxt.bresp_r = `AFR_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid_r && s_bready) begin
      st_nxt.bvalid_r = 1'b0;
    end
    st_nxt.arready_r = 1'b0;
    if (s_arvalid && !st_r.arready_r && !st_r.rvalid_r) begin
      st_nxt.arready_r = 1'b1;
      st_nxt.rvalid_r = 1'b1;
      st_nxt.rresp_r = `AFR_RESP_OKAY;
      unique case (s_araddr)
        `AFR_OFS_CAUSE: st_nxt.rdata_r = cause_word;
        `AFR_OFS_ADDR: st_nxt.rdata_r = st_r.addr_r;
        `AFR_OFS_KIND: st_nxt.rdata_r = {31'h00000000, st_r.kind_r};
        default: begin
          st_nxt.rdata_r = 32'h0000_0000;
          st_nxt.rresp_r = `AFR_RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid_r && s_rready) begin
      st_nxt.rvalid_r = 1'b0;
    end
    // An abort in the same cycle as a software write wins: the hardware source must not be lost.
    if (abort_in.valid) begin
      st_nxt.kind_r = abort_in.kind;
      st_nxt.cause_r = abort_in.cause;
      if (abort_in.cause.dbg) begin
        // Domain and extension are undefined after a debug event; zero keeps them harmless.
        st_nxt.cause_r.ext = 1'b0;
        st_nxt.cause_r.domain = 4'h0;
      end
      if (abort_in.kind == AFR_DATA) begin
        st_nxt.addr_r = abort_in.vaddr;
      end
      else begin
        st_nxt.cause_r.domain = 4'h0;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end
    else begin
      st_r <= st_nxt;
    end
  end

  assign s_awready = !st_r.aw_held_r;
  assign s_wready = !st_r.w_held_r;
  assign s_bvalid = st_r.bvalid_r;
  assign s_bresp = st_r.bresp_r;
  assign s_arready = st_r.arready_r;
  assign s_rvalid = st_r.rvalid_r;
  assign s_rdata = st_r.rdata_r;
  assign s_rresp = st_r.rresp_r;
  assign abort_cause_status = st_r.cause_r;
  assign abort_virtual_address = st_r.addr_r;
endmodule
